// [design/ppom_cfg.svh]
// Constants for the port pin override multiplexer.
// Assumes inclusion by the package, the port logic and its assertions.
`ifndef PPOM_CFG_SVH
`define PPOM_CFG_SVH
`define PPOM_PIN_COUNT   4
`define PPOM_RST_OUT     4'h0
`define PPOM_RST_DIR     4'h0
`define PPOM_RST_PULL    4'h0
`endif

// [design/ppom_pkg.sv]
// Types shared by the port pin override multiplexer files.
// Assumes the cfg header is on the include path.
`include "ppom_cfg.svh"
package ppom_pkg;
  typedef logic [`PPOM_PIN_COUNT-1:0] ppom_pins_t;
  // Registered state of the port: output, direction, pull-up, sync stages.
  typedef struct packed {
    ppom_pins_t outVal;
    ppom_pins_t dirVal;
    ppom_pins_t pullVal;
    ppom_pins_t syncA;
    ppom_pins_t syncB;
  } ppom_state_t;
endpackage

// [design/ppom_pin_mux.sv]
// Combinational override multiplexer for one port pin.
// Assumes the owning alternate function drives its enables and values.
`timescale 1ns/10ps
module ppom_pin_mux
  import ppom_pkg::*;
(
  // Port register bits.
  input  wire logic pullupBit,
  input  wire logic driveSelectBit,
  input  wire logic outputValueBit,
  // Controller state.
  input  wire logic inReset,
  input  wire logic sleepClamp,
  // Per-pin override signals.
  input  wire logic pullupOverrideEn,
  input  wire logic pullupOverrideVal,
  input  wire logic driveOverrideEn,
  input  wire logic driveOverrideVal,
  input  wire logic valueOverrideEn,
  input  wire logic valueOverrideVal,
  input  wire logic toggleOverrideEn,
  input  wire logic inputEnOverrideEn,
  input  wire logic inputEnOverrideVal,
  // Pad side.
  output logic      pullupOn,
  output logic      driverOn,
  output logic      padOut,
  output logic      inputOn
);
  logic portBit;

  // Toggle override flips the register bit before the value choice.
  assign portBit  = outputValueBit ^ toggleOverrideEn;
  // Pull-up is forced off in reset so the pin floats as documented.
  assign pullupOn = ~inReset &
                    (pullupOverrideEn ? pullupOverrideVal
                                      : pullupBit);
  // Driver direction: one means output.
  assign driverOn = ~inReset &
                    (driveOverrideEn ? driveOverrideVal
                                     : driveSelectBit);
  // Value only reaches the pad while the driver is on.
  assign padOut   = driverOn &
                    (valueOverrideEn ? valueOverrideVal
                                     : portBit);
  // Clamp applies only in deep sleep; reset and idle keep inputs live.
  assign inputOn  = inputEnOverrideEn ? inputEnOverrideVal
                                      : ~sleepClamp;
endmodule

// [design/ppom_port.sv]
// Four-pin port with per-pin alternate-function overrides.
// Assumes one I/O clock; pad input is asynchronous and raw for modules.
`timescale 1ns/10ps
`include "ppom_cfg.svh"

// Summary of operation
// - Pull-up override enable selects the override value for the pull-up.
// - Without override, pull-up follows the pull-up register bit.
// - Under override, value one enables and zero disables the pull-up.
// - Direction override enable drives the driver enable from its value.
// - Without override, driver enable follows the direction bit.
// - Value override puts its value on a driven pin.
// - Without value override, a driven pin shows the output bit.
// - Toggle override inverts the output register bit.
// - Input-enable override sets the digital input enable directly.
// - Without override, input enable follows normal versus sleep state.
// - Modules get the raw Schmitt output, before the read synchroniser.
// - Strobes shared per port, clock and clamp global, overrides per pin.
// - Pull-ups are held off while reset is active.
// - Inputs stay enabled in reset, active and idle; off in deep sleep.
// - Direction bit one makes an output, zero an input.
// - Sleep clamp grounds the input unless an override keeps it on.
module ppom_port
  import ppom_pkg::*;
(
  // Clock and reset.
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  // Register strobes shared by all pins of the port.
  input  wire logic       writeOut,
  input  wire logic       writeDir,
  input  wire logic       writePull,
  input  wire logic       writeToggle,
  input  wire logic [3:0] writeData,
  // Sleep clamp shared by all ports.
  input  wire logic       sleepClamp,
  // Per-pin overrides from alternate-function modules.
  input  wire logic [3:0] pullup_override_en,
  input  wire logic [3:0] pullup_override_val,
  input  wire logic [3:0] drive_override_en,
  input  wire logic [3:0] drive_override_val,
  input  wire logic [3:0] value_override_en,
  input  wire logic [3:0] value_override_val,
  input  wire logic [3:0] toggle_override_en,
  input  wire logic [3:0] input_en_override_en,
  input  wire logic [3:0] input_en_override_val,
  // Register read-back.
  output logic      [3:0] output_value_bit,
  output logic      [3:0] drive_select_bit,
  output logic      [3:0] pullup_bit,
  output logic      [3:0] pinRead,
  // Alternate-function input, unsynchronised.
  output logic      [3:0] alt_fn_input,
  // Pad control.
  input  wire logic [3:0] padIn,
  output logic      [3:0] padOut,
  output logic      [3:0] padOe,
  output logic      [3:0] padPullup
);
  ppom_state_t stateQ;
  ppom_state_t stateD;
  logic [3:0] inputOn;
  logic [3:0] schmitt;
  logic       inReset;

  // Reset is asynchronous so the pad floats even without a clock.
  assign inReset = ~resetn;

  // Register writes use shared strobes; a toggle write flips the bits.
  always_comb begin
    stateD = stateQ;
    if (writeOut) begin
      stateD.outVal = writeData;
    end
    if (writeToggle) begin
      stateD.outVal = stateQ.outVal ^ writeData;
    end
    if (writeDir) begin
      stateD.dirVal = writeData;
    end
    if (writePull) begin
      stateD.pullVal = writeData;
    end
    // The first stage feeds only the second.
    stateD.syncA = schmitt;
    stateD.syncB = stateQ.syncA;
  end

  // One register for all port state.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      stateQ <= '{outVal: `PPOM_RST_OUT, dirVal: `PPOM_RST_DIR,
                  pullVal: `PPOM_RST_PULL, syncA: 4'h0, syncB: 4'h0};
    end else begin
      stateQ <= stateD;
    end
  end

  // Clamped inputs read as ground, which blocks floating-input current.
  assign schmitt      = padIn & inputOn;
  // Raw input goes out before any flop; consumers must synchronise it.
  assign alt_fn_input = schmitt;
  assign pinRead      = stateQ.syncB;
  assign output_value_bit = stateQ.outVal;
  assign drive_select_bit = stateQ.dirVal;
  assign pullup_bit       = stateQ.pullVal;

  // One mux per pin; each override reaches only its own pin.
  for (genvar i = 0; i < `PPOM_PIN_COUNT; i++) begin : gPin
    ppom_pin_mux uMux (
      .pullupBit          (stateQ.pullVal[i]),
      .driveSelectBit     (stateQ.dirVal[i]),
      .outputValueBit     (stateQ.outVal[i]),
      .inReset            (inReset),
      .sleepClamp         (sleepClamp),
      .pullupOverrideEn   (pullup_override_en[i]),
      .pullupOverrideVal  (pullup_override_val[i]),
      .driveOverrideEn    (drive_override_en[i]),
      .driveOverrideVal   (drive_override_val[i]),
      .valueOverrideEn    (value_override_en[i]),
      .valueOverrideVal   (value_override_val[i]),
      .toggleOverrideEn   (toggle_override_en[i]),
      .inputEnOverrideEn  (input_en_override_en[i]),
      .inputEnOverrideVal (input_en_override_val[i]),
      .pullupOn           (padPullup[i]),
      .driverOn           (padOe[i]),
      .padOut             (padOut[i]),
      .inputOn            (inputOn[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks on the pad-side results.

  property p_pull_ovr;
    @(posedge ref_clk) disable iff (!resetn)
      pullup_override_en[0] |-> padPullup[0] == pullup_override_val[0];
  endproperty
  a_pull_ovr: assert property (p_pull_ovr)
    else $error("Pull-up ignores override value.");

  property p_pull_reg;
    @(posedge ref_clk) disable iff (!resetn)
      !pullup_override_en[1] |-> padPullup[1] == stateQ.pullVal[1];
  endproperty
  a_pull_reg: assert property (p_pull_reg)
    else $error("Pull-up does not follow its register bit.");

  property p_drv_ovr;
    @(posedge ref_clk) disable iff (!resetn)
      drive_override_en[2] |-> padOe[2] == drive_override_val[2];
  endproperty
  a_drv_ovr: assert property (p_drv_ovr)
    else $error("Driver ignores direction override.");

  sequence s_dir_write;
    writeDir && !drive_override_en[0] ##1 !drive_override_en[0];
  endsequence
  property p_dir_reg;
    @(posedge ref_clk) disable iff (!resetn)
      s_dir_write |-> padOe[0] == $past(writeData[0]);
  endproperty
  a_dir_reg: assert property (p_dir_reg)
    else $error("Driver does not follow written direction bit.");

  property p_val_ovr;
    @(posedge ref_clk) disable iff (!resetn)
      value_override_en[3] && padOe[3] |->
        padOut[3] == value_override_val[3];
  endproperty
  a_val_ovr: assert property (p_val_ovr)
    else $error("Pad value ignores value override.");

  property p_val_tog;
    @(posedge ref_clk) disable iff (!resetn)
      !value_override_en[1] && padOe[1] |->
        padOut[1] == (stateQ.outVal[1] ^ toggle_override_en[1]);
  endproperty
  a_val_tog: assert property (p_val_tog)
    else $error("Pad value wrong from output bit and toggle.");

  property p_in_ovr;
    @(posedge ref_clk) disable iff (!resetn)
      input_en_override_en[2] && !input_en_override_val[2] |->
        alt_fn_input[2] == 1'b0;
  endproperty
  a_in_ovr: assert property (p_in_ovr)
    else $error("Input not disabled by override.");

  property p_clamp;
    @(posedge ref_clk) disable iff (!resetn)
      !input_en_override_en[0] |->
        alt_fn_input[0] == (padIn[0] & !sleepClamp);
  endproperty
  a_clamp: assert property (p_clamp)
    else $error("Sleep clamp handling wrong.");

  property p_sync;
    @(posedge ref_clk) disable iff (!resetn)
      ##2 pinRead[3] == $past(alt_fn_input[3], 2);
  endproperty
  a_sync: assert property (p_sync)
    else $error("Read path is not two stages behind raw input.");
endmodule

// [verif/ppom_far_model.sv]
// Far side of the port: the external pad and one alternate-function user.
// Assumes pad controls come straight from the port under test.
`timescale 1ns/10ps
module ppom_far_model (
  // Clock and reset.
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  // Pad control and the external source level.
  input  wire logic [3:0] padOut,
  input  wire logic [3:0] padOe,
  input  wire logic [3:0] extLevel,
  output logic      [3:0] padIn,
  // Raw alternate input and its synchronised copy.
  input  wire logic [3:0] altIn,
  output logic      [3:0] altSync
);
  logic [3:0] stageQ;

  // The port driver wins; otherwise the external source sets the pad.
  assign padIn = (padOe & padOut) | (~padOe & extLevel);

  ////////////////////////////////////////////////////////////////////////////
  // The raw input is asynchronous, so this user keeps two stages of its own.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      stageQ  <= 4'h0;
      altSync <= 4'h0;
    end else begin
      stageQ  <= altIn;
      altSync <= stageQ;
    end
  end
endmodule

// [verif/ppom_port_tb_top.sv]
// Self-checking bench for the four-pin override port.
// Assumes the far-side model file is compiled before this one.
`timescale 1ns/10ps
module ppom_port_tb_top;
  logic       ref_clk;
  logic       resetn;
  logic [3:0] wr;
  logic [3:0] writeData;
  logic       sleepClamp;
  logic [3:0] ov [9];
  logic [3:0] extLevel;
  logic [3:0] outBits, dirBits, pullBits, pinRead, altIn, altSync;
  logic [3:0] padIn, padOut, padOe, padPullup;
  logic [3:0] outR, dirR, pullR;
  int         fails, cmp_count;

  ppom_port u_ppom_port (
    .ref_clk(ref_clk), .resetn(resetn), .writeOut(wr[0]),
    .writeDir(wr[1]), .writePull(wr[2]), .writeToggle(wr[3]),
    .writeData(writeData), .sleepClamp(sleepClamp),
    .pullup_override_en(ov[0]), .pullup_override_val(ov[1]),
    .drive_override_en(ov[2]), .drive_override_val(ov[3]),
    .value_override_en(ov[4]), .value_override_val(ov[5]),
    .toggle_override_en(ov[6]), .input_en_override_en(ov[7]),
    .input_en_override_val(ov[8]), .output_value_bit(outBits),
    .drive_select_bit(dirBits), .pullup_bit(pullBits),
    .pinRead(pinRead), .alt_fn_input(altIn), .padIn(padIn),
    .padOut(padOut), .padOe(padOe), .padPullup(padPullup));

  ppom_far_model u_ppom_far_model (
    .ref_clk(ref_clk), .resetn(resetn), .padOut(padOut), .padOe(padOe),
    .extLevel(extLevel), .padIn(padIn), .altIn(altIn), .altSync(altSync));

  ////////////////////////////////////////////////////////////////////////////
  // The clock toggles every 20 ns, giving a 40 ns period.
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic cmp(input logic [3:0] got, input logic [3:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One-cycle strobe; the expected register copy follows the write.
  task automatic wrt(input int k, input logic [3:0] d);
    @(negedge ref_clk);
    wr[k] = 1'b1;
    writeData = d;
    @(negedge ref_clk);
    wr[k] = 1'b0;
    if (k == 0) outR = d;
    if (k == 1) dirR = d;
    if (k == 2) pullR = d;
    if (k == 3) outR = outR ^ d;
  endtask

  function automatic logic [3:0] expIn();
    return (ov[7] & ov[8]) | (~ov[7] & {4{~sleepClamp}});
  endfunction

  // Pads are combinational, so they are checked in the driving cycle.
  task automatic chk_pads();
    logic [3:0] eo, ev, ep;
    eo = (ov[2] & ov[3]) | (~ov[2] & dirR);
    ev = (ov[4] & ov[5]) | (~ov[4] & (outR ^ ov[6]));
    // Expected pad level: our driver wins, else the external source.
    ep = (eo & ev) | (~eo & extLevel);
    cmp(padPullup, (ov[0] & ov[1]) | (~ov[0] & pullR));
    cmp(padOe, eo);
    cmp(padOut & eo, ev & eo);
    cmp(altIn, ep & expIn());
  endtask

  task automatic wrap_up();
    $display("Compares %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // A hang costs far more than the hundred or so cycles the tests need.
  initial begin
    #80000;
    fails++;
    wrap_up();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: register writes, override sweep, resync, mid-run reset.
  initial begin
    {wr, writeData, sleepClamp, extLevel, outR, dirR, pullR} = '0;
    foreach (ov[k]) ov[k] = 4'h0;
    resetn = 1'b0;
    repeat (10) @(negedge ref_clk);
    resetn = 1'b1;
    wrt(2, 4'hc);
    wrt(1, 4'h5);
    wrt(0, 4'h3);
    wrt(3, 4'h6);
    cmp(outBits, outR);
    cmp(dirBits, dirR);
    cmp(pullBits, pullR);
    for (int n = 0; n < 64; n++) begin
      if (n % 16 == 0) wrt(1, 4'(n >> 4));
      @(negedge ref_clk);
      for (int k = 0; k < 9; k++) ov[k] = 4'(n * (k + 3) + k * 5);
      sleepClamp = n[2];
      extLevel = 4'(n + 9);
      #1;
      chk_pads();
    end
    repeat (3) @(negedge ref_clk);
    cmp(pinRead, padIn & expIn());
    cmp(altSync, altIn);
    foreach (ov[k]) ov[k] = 4'h0;
    sleepClamp = 1'b0;
    wrt(2, 4'hf);
    wrt(1, 4'hf);
    @(negedge ref_clk);
    resetn = 1'b0;
    #1;
    cmp(padPullup, 4'h0);
    cmp(padOe, 4'h0);
    cmp(altIn, extLevel);
    {outR, dirR, pullR} = '0;
    @(negedge ref_clk);
    resetn = 1'b1;
    cmp(pullBits, pullR);
    cmp(dirBits, dirR);
    wrap_up();
  end
endmodule
